// file: rtl/button_press.sv
// Purpose: Debounce front-panel buttons and emit one pulse per press
// Assumes: Button levels are synchronous to core_clk, active high
// Notes:   A held button yields a single pulse
`timescale 1ns/10ps
module button_press #(
    parameter int WIDTH      = 3,
    parameter int STABLE_CYC = 1_000_000
) (
    input  wire logic             core_clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] press
);

    initial begin
        if (STABLE_CYC < 1 || WIDTH < 1)
            $error("button_press: bad parameters");
    end

    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] next_stable;
    logic [WIDTH-1:0] next_press;
    logic [31:0]      cnt [WIDTH];
    logic [31:0]      next_cnt [WIDTH];

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_cnt[i]    = 32'h0;
            next_stable[i] = stable[i];
            next_press[i]  = 1'b0;
            if (raw[i] != stable[i]) begin
                next_cnt[i] = cnt[i] + 32'h1;
                if (cnt[i] >= 32'(STABLE_CYC - 1)) begin
                    next_cnt[i]    = 32'h0;
                    next_stable[i] = raw[i];
                    next_press[i]  = raw[i];
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            stable <= '0;
            press  <= '0;
            for (int i = 0; i < WIDTH; i++)
                cnt[i] <= 32'h0;
        end else begin
            stable <= next_stable;
            press  <= next_press;
            cnt    <= next_cnt;
        end
    end

endmodule

// file: rtl/pps_clock.sv
// Purpose: Time-of-day clock, 1 Hz pulse generator and phase shifter
// Assumes: ref_5mhz and ext_sync sampled on core_clk; APB zero-wait slave
// Notes:   Display fields are binary; shift offset counts 50 ns steps
`timescale 1ns/10ps

// Functional notes
// - Pulse and clock timing is counted from the 5 MHz reference edges.
// - Time line shows hours, minutes, seconds; date line shows the calendar.
// - Weekday runs 1 for Monday to 7 for Sunday and advances each day.
// - Cursor moves one digit right per press and wraps to the next line.
// - Plus and minus change the clock digit under the cursor by one.
// - On the seconds-adjust position plus and minus move the clock 10 s.
// - On the offset line plus delays the pulse, minus advances it.
// - The least significant offset digit is one 50 ns phase step.
// - The offset shows the signed total of all shifts applied.
// - Ready shows while idle, busy during a shift; shifts ignored when busy.
// - A 100 ms shift is spread out over about five seconds.
// - A sync rising edge realigns the pulse and clears the offset.
// - A sync edge on the own pulse clears the offset without moving it.
module pps_clock
#(
    parameter int STEPS_SEC  = pps_clock_pkg::STEPS_PER_SEC,
    parameter int SLEW_MAX   = pps_clock_pkg::SLEW_PER_SEC,
    parameter int DEBOUNCE   = pps_clock_pkg::DEBOUNCE_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        ref_5mhz,
    input  wire logic        ext_sync,
    input  wire logic        btn_cursor,
    input  wire logic        btn_plus,
    input  wire logic        btn_minus,
    output logic             pps_out,
    output logic [4:0]       cursor,
    output logic [6:0]       hours,
    output logic [6:0]       minutes,
    output logic [6:0]       seconds,
    output logic [6:0]       day,
    output logic [6:0]       month,
    output logic [6:0]       year,
    output logic [6:0]       weekday,
    output logic [31:0]      shift_total,
    output logic             ready,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    import pps_clock_pkg::*;

    initial begin
        if (STEPS_SEC <= PULSE_STEPS || SLEW_MAX < 1 ||
            SLEW_MAX >= STEPS_SEC / 2 || DEBOUNCE < 1)
            $error("pps_clock: bad parameters");
    end
    function automatic logic [6:0] wrap_step(input logic [6:0] v,
                                             input int d, input int lo,
                                             input int hi);
        int r;
        r = int'(v) + d;
        if (r > hi)
            r = r - (hi - lo + 1);
        if (r < lo)
            r = r + (hi - lo + 1);
        return 7'(r);
    endfunction
    function automatic logic [6:0] days_in(input logic [6:0] m,
                                           input logic [6:0] y);
        case (m)
            7'h04, 7'h06, 7'h09, 7'h0b: return 7'h1e;
            7'h02: return (y[1:0] == 2'b00) ? 7'h1d : 7'h1c;
            default: return 7'h1f;
        endcase
    endfunction
    function automatic logic [31:0] ofs_weight(input logic [4:0] pos);
        case (pos - CUR_OFS_FIRST)
            5'h00:   return 32'h05f5_e100;
            5'h01:   return 32'h0098_9680;
            5'h02:   return 32'h000f_4240;
            5'h03:   return 32'h0001_86a0;
            5'h04:   return 32'h0000_2710;
            5'h05:   return 32'h0000_03e8;
            5'h06:   return 32'h0000_0064;
            5'h07:   return 32'h0000_000a;
            default: return 32'h0000_0001;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Buttons
    logic [2:0] press;
    button_press #(
        .WIDTH      (3),
        .STABLE_CYC (DEBOUNCE)
    ) u_buttons (
        .core_clk (core_clk),
        .srst     (srst),
        .raw      ({btn_minus, btn_plus, btn_cursor}),
        .press    (press)
    );
    ////////////////////////////////////////////////////////////////////////
    // Phase timing
    logic        ref_prev;
    logic        sync_prev;
    logic [2:0]  sub;
    logic [2:0]  next_sub;
    logic [31:0] phase;
    logic [31:0] next_phase;
    logic [31:0] adj;
    logic [31:0] next_adj;
    logic [31:0] pending;
    logic [31:0] next_pending;
    logic [31:0] next_total;
    logic        second_end;
    logic        sync_edge;
    logic        step_tick;
    logic        busy;
    logic        shift_req;
    logic [31:0] shift_amt;
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    assign sync_edge = ext_sync & ~sync_prev;
    assign busy      = (pending != 32'h0) || (adj != 32'h0);
    assign step_tick = (sub == 3'(CYC_PER_STEP - 1));
    assign second_end = step_tick &&
        ($signed(phase) >= $signed(32'(STEPS_SEC - 1)) + $signed(adj));
    always_comb begin
        shift_req = 1'b0;
        shift_amt = 32'h0;
        if (cursor >= CUR_OFS_FIRST && (press[1] ^ press[2])) begin
            shift_req = 1'b1;
            shift_amt = press[1] ? ofs_weight(cursor)
                                 : 32'h0 - ofs_weight(cursor);
        end
    end
    always_comb begin
        next_sub = (sub == 3'(CYC_PER_STEP - 1)) ? 3'h0 : sub + 3'h1;
        if (ref_5mhz && !ref_prev)
            next_sub = 3'h1;
        next_phase   = phase;
        next_adj     = adj;
        next_pending = pending;
        next_total   = shift_total;
        if (step_tick)
            next_phase = phase + 32'h1;
        if (second_end) begin
            next_phase   = 32'h0;
            if ($signed(pending) > $signed(32'(SLEW_MAX)))
                next_adj = 32'(SLEW_MAX);
            else if ($signed(pending) < -$signed(32'(SLEW_MAX)))
                next_adj = 32'h0 - 32'(SLEW_MAX);
            else
                next_adj = pending;
            next_pending = pending - next_adj;
        end
        if (shift_req && !busy) begin
            next_pending = next_pending + shift_amt;
            next_total   = shift_total + shift_amt;
        end
        if (sync_edge) begin
            // own-pulse edge lands on phase zero, so no move
            next_phase   = 32'h0;
            next_adj     = 32'h0;
            next_pending = 32'h0;
            next_total   = 32'h0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ref_prev    <= 1'b0;
            sync_prev   <= 1'b0;
            sub         <= 3'h0;
            phase       <= 32'h0;
            adj         <= 32'h0;
            pending     <= 32'h0;
            shift_total <= 32'h0;
            pps_out     <= 1'b0;
            ready       <= 1'b1;
        end else begin
            ref_prev    <= ref_5mhz;
            sync_prev   <= ext_sync;
            sub         <= next_sub;
            phase       <= next_phase;
            adj         <= next_adj;
            pending     <= next_pending;
            shift_total <= next_total;
            pps_out     <= ctrl[0] && (next_phase < 32'(PULSE_STEPS));
            ready       <= (next_pending == 32'h0) && (next_adj == 32'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock and calendar
    logic [4:0] next_cursor;
    logic [6:0] nh;
    logic [6:0] nm;
    logic [6:0] ns;
    logic [6:0] nd;
    logic [6:0] nmo;
    logic [6:0] ny;
    logic [6:0] nw;
    always_comb begin
        int d;
        d   = 0;
        nh  = hours;
        nm  = minutes;
        ns  = seconds;
        nd  = day;
        nmo = month;
        ny  = year;
        nw  = weekday;
        next_cursor = cursor;
        if (press[0])
            next_cursor = (cursor == CUR_LAST) ? 5'h00 : cursor + 5'h01;
        if (second_end) begin
            ns = wrap_step(ns, 1, 0, 59);
            if (ns == 7'h00) begin
                nm = wrap_step(nm, 1, 0, 59);
                if (nm == 7'h00) begin
                    nh = wrap_step(nh, 1, 0, 23);
                    if (nh == 7'h00) begin
                        nw = wrap_step(nw, 1, 1, 7);
                        if (nd >= days_in(nmo, ny)) begin
                            nd  = 7'h01;
                            nmo = wrap_step(nmo, 1, 1, 12);
                            if (nmo == 7'h01)
                                ny = wrap_step(ny, 1, 0, 99);
                        end else begin
                            nd = nd + 7'h01;
                        end
                    end
                end
            end
        end
        if (press[1] ^ press[2])
            d = press[1] ? 1 : -1;
        if (d != 0 && cursor < CUR_OFS_FIRST) begin
            case (cursor)
                5'h00:       nh  = wrap_step(nh, 10 * d, 0, 23);
                5'h01:       nh  = wrap_step(nh, d, 0, 23);
                5'h02:       nm  = wrap_step(nm, 10 * d, 0, 59);
                5'h03:       nm  = wrap_step(nm, d, 0, 59);
                5'h04:       ns  = wrap_step(ns, 10 * d, 0, 59);
                5'h05:       ns  = wrap_step(ns, d, 0, 59);
                CUR_SEC_ADJ: begin
                    if (d > 0 && ns >= 7'h32)
                        nm = wrap_step(nm, 1, 0, 59);
                    if (d < 0 && ns < 7'h0a)
                        nm = wrap_step(nm, -1, 0, 59);
                    ns = wrap_step(ns, 10 * d, 0, 59);
                end
                5'h07:       nd  = wrap_step(nd, 10 * d, 1, 31);
                5'h08:       nd  = wrap_step(nd, d, 1, 31);
                5'h09:       nmo = wrap_step(nmo, 10 * d, 1, 12);
                5'h0a:       nmo = wrap_step(nmo, d, 1, 12);
                5'h0b:       ny  = wrap_step(ny, 10 * d, 0, 99);
                5'h0c:       ny  = wrap_step(ny, d, 0, 99);
                CUR_WEEKDAY: nw  = wrap_step(nw, d, 1, 7);
                default:     nh  = hours;
            endcase
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cursor  <= 5'h00;
            hours   <= 7'h00;
            minutes <= 7'h00;
            seconds <= 7'h00;
            day     <= RST_DAY;
            month   <= RST_MONTH;
            year    <= RST_YEAR;
            weekday <= RST_WEEKDAY;
        end else begin
            cursor  <= next_cursor;
            hours   <= nh;
            minutes <= nm;
            seconds <= ns;
            day     <= nd;
            month   <= nmo;
            year    <= ny;
            weekday <= nw;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave; read data is latched in the setup cycle
    logic        hit;
    logic [31:0] rd_word;
    logic [31:0] next_prdata;
    assign pready = 1'b1;
    always_comb begin
        hit         = 1'b1;
        rd_word     = 32'h0;
        next_ctrl   = ctrl;
        case (paddr)
            OFS_CTRL:   rd_word = ctrl;
            OFS_TIME:   rd_word = {11'h0, hours, minutes, seconds};
            OFS_DATE:   rd_word = {4'h0, weekday, year, month, day};
            OFS_SHIFT:  rd_word = shift_total;
            OFS_STATUS: rd_word = {26'h0, cursor, busy};
            default:    hit     = 1'b0;
        endcase
        next_prdata = (psel && !penable) ? rd_word : prdata;
        pslverr     = psel && penable && !hit;
        if (psel && penable && pwrite && paddr == OFS_CTRL)
            next_ctrl = {31'h0, pwdata[0]};
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl   <= RST_CTRL;
            prdata <= 32'h0;
        end else begin
            ctrl   <= next_ctrl;
            prdata <= next_prdata;
        end
    end

endmodule

// file: rtl/pps_clock_pkg.sv
// Purpose: Shared constants for the pulse-per-second clock and shifter
// Assumes: 100 MHz core clock, 5 MHz reference sampled on that clock
// Notes:   Phase counts are in 50 ns steps; offsets are APB byte addresses
package pps_clock_pkg;

    // Clocking
    localparam int CLK_PERIOD_NS     = 10;
    localparam int REF_HZ            = 5_000_000;
    localparam int STEP_NS           = 50;
    localparam int CYC_PER_STEP      = STEP_NS / CLK_PERIOD_NS;
    localparam int STEPS_PER_SEC     = 1_000_000_000 / STEP_NS;

    // Gradual shift: 100 ms spread over about 5 s
    localparam int BIG_STEP_MS       = 100;
    localparam int BIG_STEP_SECONDS  = 5;
    localparam int SLEW_PER_SEC      =
        (BIG_STEP_MS * 1_000_000 / STEP_NS) / BIG_STEP_SECONDS;

    // Output pulse width and button debounce
    localparam int PULSE_US          = 10;
    localparam int PULSE_STEPS       = PULSE_US * 1000 / STEP_NS;
    localparam int DEBOUNCE_MS       = 10;
    localparam int DEBOUNCE_CYC      = DEBOUNCE_MS * 1_000_000 / CLK_PERIOD_NS;

    // Cursor positions
    localparam logic [4:0] CUR_SEC_UNITS  = 5'h05;
    localparam logic [4:0] CUR_SEC_ADJ    = 5'h06;
    localparam logic [4:0] CUR_WEEKDAY    = 5'h0d;
    localparam logic [4:0] CUR_OFS_FIRST  = 5'h0e;
    localparam logic [4:0] CUR_LAST       = 5'h16;

    // Reset values of the calendar
    localparam logic [6:0] RST_DAY     = 7'h01;
    localparam logic [6:0] RST_MONTH   = 7'h01;
    localparam logic [6:0] RST_YEAR    = 7'h00;
    localparam logic [6:0] RST_WEEKDAY = 7'h01;

    // Register map
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_TIME    = 8'h04;
    localparam logic [7:0] OFS_DATE    = 8'h08;
    localparam logic [7:0] OFS_SHIFT   = 8'h0c;
    localparam logic [7:0] OFS_STATUS  = 8'h10;
    localparam logic [31:0] RST_CTRL   = 32'h0000_0001;

endpackage

// file: verification/pps_clock_checker.sv
// Purpose: Port-level assertions for the pps clock and shifter
// Assumes: One core_clk domain, srst synchronous and active high
// Notes:   Bound to the design from the bench top file
`timescale 1ns/10ps
module pps_clock_checker (
    input wire logic        core_clk,
    input wire logic        srst,
    input wire logic        ext_sync,
    input wire logic        btn_cursor,
    input wire logic        pps_out,
    input wire logic [4:0]  cursor,
    input wire logic [6:0]  weekday,
    input wire logic [31:0] shift_total,
    input wire logic        ready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////
    chk_cursor_range: assert property (cursor <= 5'h16)
        else $error("cursor out of range");
    chk_weekday_range: assert property
        (weekday >= 7'h01 && weekday <= 7'h07)
        else $error("weekday out of range");
    chk_cursor_cause: assert property
        (cursor != $past(cursor) |-> $past(btn_cursor, 2))
        else $error("cursor moved without a press");
    chk_single_step: assert property
        (cursor != $past(cursor) |=> $stable(cursor) [*8])
        else $error("cursor moved twice for one press");
    chk_sync_clear: assert property
        ($rose(ext_sync) |-> ##[1:3] shift_total == 32'h0)
        else $error("sync did not clear the offset");
    chk_sync_align: assert property
        ($rose(ext_sync) && !pps_out |-> ##[1:4] $rose(pps_out))
        else $error("sync did not realign the pulse");
    chk_busy_hold: assert property
        (!$past(ready) && shift_total != 32'h0 |-> $stable(shift_total))
        else $error("shift taken while busy");
    chk_shift_busy: assert property
        ($changed(shift_total) && shift_total != 32'h0 |-> ##[0:1] !ready)
        else $error("no busy state after a shift");
endmodule

// file: verification/pps_clock_tb.sv
// Purpose: Self-checking bench for the pps clock and shifter
// Assumes: Second, slew and debounce counts shortened
// Notes:   One task per scenario; APB transfers wait for pready
`timescale 1ns/10ps
module pps_clock_tb;
    import pps_clock_pkg::*;
    localparam int SEC = 400;
    localparam int PER = SEC * CYC_PER_STEP;
    logic        core_clk   = 1'b0;
    logic        srst       = 1'b1;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [7:0]  paddr      = 8'h00;
    logic [31:0] pwdata     = 32'h0;
    logic        ref_5mhz, ext_sync, btn_cursor, btn_plus, btn_minus;
    logic        pps_out, ready, pready, pslverr;
    logic [31:0] prdata, shift_total;
    logic [4:0]  cursor;
    logic [6:0]  hours, minutes, seconds, day, month, year, weekday;
    time         rise_t     = 0;
    int          failures   = 0;
    int          n_compared = 0;

    pps_clock #(.STEPS_SEC(SEC), .SLEW_MAX(20), .DEBOUNCE(4)) dut_u (
        .core_clk, .srst, .ref_5mhz, .ext_sync, .btn_cursor, .btn_plus,
        .btn_minus, .pps_out, .cursor, .hours, .minutes, .seconds, .day,
        .month, .year, .weekday, .shift_total, .ready, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    pps_panel_model panel_u (
        .core_clk, .pps_out, .ref_5mhz, .ext_sync, .btn_cursor,
        .btn_plus, .btn_minus);

    initial begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge pps_out) rise_t = $time;
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            failures++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] d,
                       output logic e);
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        d = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input string nm);
        logic [31:0] d;
        logic        e;
        apb(1'b0, a, 32'h0, d, e);
        chk(nm, x, d);
    endtask
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] d;
        logic        e;
        rd(OFS_CTRL, RST_CTRL, "ctrl");
        rd(OFS_TIME, 32'h0, "time");
        rd(OFS_DATE, 32'h0020_0081, "date");
        rd(OFS_STATUS, 32'h0, "status");
        apb(1'b1, OFS_CTRL, 32'h0, d, e);
        rd(OFS_CTRL, 32'h0, "ctrl_wr");
        chk("pps_off", 32'h0, {31'h0, pps_out});
        apb(1'b1, OFS_CTRL, 32'h1, d, e);
        apb(1'b0, 8'h14, 32'h0, d, e);
        chk("unmapped", 32'h1, {31'h0, e});
        $display("t_regs done");
    endtask
    task automatic t_edit();
        logic [6:0] s0;
        logic [6:0] dd;
        panel_u.press(1, 40);
        chk("hours_up", 32'd10, hours);
        panel_u.press(2, 10);
        chk("hours_dn", 32'd0, hours);
        panel_u.btn <= 3'h6;
        repeat (10) @(posedge core_clk);
        panel_u.btn <= 3'h0;
        repeat (10) @(posedge core_clk);
        chk("both_ignored", 32'd0, hours);
        repeat (3) panel_u.press(0, 10);
        panel_u.press(1, 10);
        chk("min_up", 32'd1, minutes);
        repeat (3) panel_u.press(0, 10);
        chk("cursor6", 32'd6, cursor);
        s0 = seconds;
        panel_u.press(1, 10);
        dd = (seconds + 7'd60 - s0) % 7'd60;
        chk("sec_adj", 32'h1, {31'h0, dd == 7'd10 || dd == 7'd11});
        panel_u.press(0, 10);
        panel_u.press(1, 10);
        repeat (3) panel_u.press(0, 10);
        panel_u.press(1, 10);
        repeat (2) panel_u.press(0, 10);
        panel_u.press(2, 10);
        rd(OFS_DATE, 32'h0038_c10b, "date_edit");
        panel_u.press(0, 10);
        repeat (6) panel_u.press(1, 10);
        chk("wday7", 32'd7, weekday);
        panel_u.press(1, 10);
        chk("wday1", 32'd1, weekday);
        repeat (7) panel_u.press(0, 10);
        chk("cursor20", 32'd20, cursor);
        $display("t_edit done");
    endtask
    task automatic t_big();
        time t0;
        t0 = $time;
        panel_u.press(1, 10);
        chk("big_total", 32'd100, shift_total);
        chk("big_busy", 32'h0, {31'h0, ready});
        panel_u.press(1, 10);
        chk("big_ignored", 32'd100, shift_total);
        while (ready !== 1'b1)
            @(posedge core_clk);
        t0 = ($time - t0) / 10;
        chk("big_slow", 32'h1, {31'h0, t0 > 8000 && t0 < 12700});
        $display("t_big done");
    endtask
    task automatic t_sync();
        time t0;
        @(negedge pps_out);
        repeat (300) @(posedge core_clk);
        t0 = $time;
        panel_u.sync_pulse();
        chk("sync_total", 32'h0, shift_total);
        chk("sync_rise", 32'h1, {31'h0, pps_out && rise_t > t0});
        $display("t_sync done");
    endtask
    task automatic t_small();
        time t0;
        repeat (2) panel_u.press(0, 10);
        chk("cursor22", 32'd22, cursor);
        @(posedge pps_out);
        t0 = $time;
        panel_u.press(1, 10);
        chk("small_total", 32'd1, shift_total);
        repeat (2) @(posedge pps_out);
        chk("stretch", 2 * PER + CYC_PER_STEP, 32'(($time - t0) / 10));
        repeat (3) @(posedge core_clk);
        chk("small_ready", 32'h1, {31'h0, ready});
        @(negedge pps_out);
        panel_u.loop <= 1'b1;
        @(posedge pps_out);
        t0 = $time;
        repeat (5) @(posedge core_clk);
        chk("loop_total", 32'h0, shift_total);
        panel_u.loop <= 1'b0;
        @(posedge pps_out);
        chk("loop_phase", PER, 32'(($time - t0) / 10));
        panel_u.press(2, 10);
        chk("minus_total", 32'hffff_ffff, shift_total);
        panel_u.press(0, 10);
        chk("cursor_wrap", 32'd0, cursor);
        $display("t_small done");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        t_regs();
        t_edit();
        t_big();
        t_sync();
        t_small();
        close_out();
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        failures++;
        close_out();
    end
endmodule

bind pps_clock pps_clock_checker chk_u (
    .core_clk, .srst, .ext_sync, .btn_cursor, .pps_out, .cursor,
    .weekday, .shift_total, .ready);

// file: verification/pps_panel_model.sv
// Purpose: Panel buttons, 5 MHz reference and external sync source
// Assumes: Drives only on core_clk rising edges
// Notes:   Loopback ties the sync input to the pulse output
`timescale 1ns/10ps
module pps_panel_model (
    input  wire logic core_clk,
    input  wire logic pps_out,
    output logic      ref_5mhz,
    output logic      ext_sync,
    output logic      btn_cursor,
    output logic      btn_plus,
    output logic      btn_minus
);
    logic [3:0] ref_cnt  = 4'h0;
    logic       ref_lvl  = 1'b0;
    logic       sync_lvl = 1'b0;
    logic       loop     = 1'b0;
    logic [2:0] btn      = 3'h0;
    assign ref_5mhz = ref_lvl;
    assign ext_sync = loop ? pps_out : sync_lvl;
    assign {btn_minus, btn_plus, btn_cursor} = btn;
    ////////////////////////////////////////////////////////////////////
    // toggle every 100 ns
    always @(posedge core_clk) begin
        ref_cnt <= (ref_cnt == 4'h9) ? 4'h0 : ref_cnt + 4'h1;
        if (ref_cnt == 4'h9) begin
            ref_lvl <= ~ref_lvl;
        end
    end
    task automatic press(input int b, input int n);
        @(posedge core_clk);
        btn[b] <= 1'b1;
        repeat (n) @(posedge core_clk);
        btn[b] <= 1'b0;
        repeat (10) @(posedge core_clk);
    endtask
    task automatic sync_pulse();
        @(posedge core_clk);
        sync_lvl <= 1'b1;
        repeat (5) @(posedge core_clk);
        sync_lvl <= 1'b0;
    endtask
endmodule
